/* File: rtl/mem_page_decoder.sv */
// Program page, data window and data space decoding with the return stack.
// Operation
// - PC bit 11 high selects static page
// - Page bits pick page when bit 11 low
// - Page register at CAh, write only
// - Page register undefined after reset
// - Readout protection blocks external memory readout
// - Reads at 40h-7Fh come from window
// - Window address is register plus low six
// - Window moves in 64 byte steps
// - Window register at C9h, seven bits
// - Window register not cleared by reset
// - Two extra RAM banks at 00h-3Fh
// - Port data, direction, option slots decoded
// - Option, window, bank, SPI disable write only
// - Stack holds six twelve bit entries
// - Dynamic pages at 000h-7FFh, static above
// - Calls and interrupts keep page register
// - Bank bit 3 page 1, bit 4 page 2
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_cfg.svh"
module mem_page_decoder #(
    parameter int PC_WIDTH = 12,
    parameter int ROM_WIDTH = 13
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Program fetch from the core.
    input wire logic [PC_WIDTH-1:0] program_counter,
    output logic [ROM_WIDTH-1:0] fetch_address,
    // Data space access from the core.
    input wire logic [7:0] data_address,
    input wire logic data_write,
    input wire logic data_read,
    input wire logic [7:0] write_data,
    // Window reads from program memory.
    output logic [ROM_WIDTH-1:0] window_address,
    output logic window_read,
    // Decoded data space target.
    output mem_map_pkg::region_t region,
    output mem_map_pkg::ram_select_t ram_select,
    output logic ram_enable,
    output logic write_only_read,
    // Return stack.
    input wire mem_map_pkg::stack_cmd_t stack_cmd,
    output logic [PC_WIDTH-1:0] stack_top,
    // Readout protection option and external readout request.
    input wire logic protect_option,
    input wire logic external_read,
    output logic external_read_allow
);
    logic [1:0] rom_page_select_bits;
    logic [6:0] data_window_upper_bits;
    logic [1:0] bank_bits;
    logic [1:0] next_rom_page_select_bits;
    logic [6:0] next_data_window_upper_bits;
    logic [1:0] next_bank_bits;
    logic [1:0] page;

    // Full byte writes load the paging registers; calls and interrupts never touch them.
    always_comb begin
        next_rom_page_select_bits = rom_page_select_bits;
        next_data_window_upper_bits = data_window_upper_bits;
        next_bank_bits = bank_bits;
        if (data_write && data_address == `ADDR_ROM_PAGE_SELECT) begin
            next_rom_page_select_bits = write_data[1:0];
        end
        if (data_write && data_address == `ADDR_WINDOW_POSITION) begin
            next_data_window_upper_bits = write_data[6:0];
        end
        if (data_write && data_address == `ADDR_RAM_BANK_SELECT) begin
            next_bank_bits = {write_data[`BANK_PAGE2_BIT], write_data[`BANK_PAGE1_BIT]};
        end
    end

    // The paging registers have no reset, so they hold garbage until written.
    always_ff @(posedge clock) begin
        rom_page_select_bits <= next_rom_page_select_bits;
        data_window_upper_bits <= next_data_window_upper_bits;
        bank_bits <= next_bank_bits;
    end

    // Upper half always fetches the static page; the lower half uses the selected page.
    always_comb begin
        page = program_counter[`PC_STATIC_BIT] ? `STATIC_PAGE : rom_page_select_bits;
        fetch_address = {page, program_counter[10:0]};
    end

    // Window address joins the register with the six low data address bits.
    always_comb begin
        window_address = {data_window_upper_bits, data_address[5:0]};
        window_read = data_read && region == mem_map_pkg::region_window;
    end

    // Data space decoding into its regions.
    always_comb begin
        region = mem_map_pkg::region_unused;
        if (data_address <= `ADDR_BANK_LAST) begin
            region = mem_map_pkg::region_bank;
        end else if (data_address < `ADDR_CORE_X) begin
            region = mem_map_pkg::region_window;
        end else if (data_address <= `ADDR_CORE_W) begin
            region = mem_map_pkg::region_core;
        end else if (data_address <= `ADDR_RAM_LAST) begin
            region = mem_map_pkg::region_ram;
        end else if (data_address < `ADDR_PORT_DIR) begin
            region = mem_map_pkg::region_port_data;
        end else if (data_address < `ADDR_IRQ_OPTION) begin
            region = mem_map_pkg::region_port_dir;
        end else if (data_address <= `ADDR_RAM_BANK_SELECT) begin
            region = mem_map_pkg::region_write_only;
        end else if (data_address < 8'hd0) begin
            region = mem_map_pkg::region_port_opt;
        end else if (data_address == `ADDR_SPI_IRQ_DISABLE) begin
            region = mem_map_pkg::region_write_only;
        end else if (data_address == `ADDR_ACCUMULATOR) begin
            region = mem_map_pkg::region_accumulator;
        end else begin
            region = mem_map_pkg::region_periph;
        end
    end

    // RAM select: banked area goes to bank 1 or 2 when chosen, else to bank 0; every other region selects bank 3, the base RAM.
    always_comb begin
        ram_select.offset = data_address[5:0];
        ram_select.bank = 2'h0;
        if (region == mem_map_pkg::region_bank) begin
            if (bank_bits[0]) ram_select.bank = 2'h1;
            else if (bank_bits[1]) ram_select.bank = 2'h2;
        end else begin
            ram_select.bank = 2'h3;
        end
        ram_enable = (data_read || data_write) &&
            (region == mem_map_pkg::region_bank || region == mem_map_pkg::region_ram);
        write_only_read = data_read && region == mem_map_pkg::region_write_only;
    end

    // Readout protection blocks outside reads of program memory.
    assign external_read_allow = external_read && !protect_option;

    return_stack #(.DEPTH(`STACK_DEPTH), .WIDTH(PC_WIDTH)) stack (
        .clock(clock),
        .rst(rst),
        .cmd(stack_cmd),
        .top(stack_top)
    );

    // Fetch mapping: the upper half is always the static page, the lower half the chosen one.
    a_static_page: assert property (@(posedge clock) disable iff (rst)
        program_counter[11] |-> fetch_address[12:11] == 2'h1) else $error("static map");
    a_dynamic_page: assert property (@(posedge clock) disable iff (rst)
        data_write && data_address == 8'hca ##1 !program_counter[11]
        |-> fetch_address[12:11] == $past(write_data[1:0])) else $error("page map");

    // Write-only registers change only on a full byte write to their own address.
    a_page_held: assert property (@(posedge clock) disable iff (rst)
        !(data_write && data_address == 8'hca) |=> $stable(rom_page_select_bits))
        else $error("page changed");
    a_window_held: assert property (@(posedge clock) disable iff (rst)
        !(data_write && data_address == 8'hc9) |=> $stable(data_window_upper_bits))
        else $error("window changed");
    a_bank_held: assert property (@(posedge clock) disable iff (rst)
        !(data_write && data_address == 8'hcb) |=> $stable(bank_bits))
        else $error("bank changed");

    // Window reads take the register as upper address bits and never reach RAM.
    a_window_addr: assert property (@(posedge clock) disable iff (rst)
        data_write && data_address == 8'hc9 |=> window_address[12:6] == $past(write_data[6:0]))
        else $error("window position");
    a_window_read: assert property (@(posedge clock) disable iff (rst)
        data_read && data_address[7:6] == 2'h1 |-> window_read && !ram_enable)
        else $error("window read");

    // Readout protection wins over any outside request.
    a_protect: assert property (@(posedge clock) disable iff (rst)
        protect_option |-> !external_read_allow) else $error("readout leak");

    // Bank select: bit 3 picks bank 1, bit 4 picks bank 2, only in the banked area.
    a_bank_one: assert property (@(posedge clock) disable iff (rst)
        data_write && data_address == 8'hcb && write_data == 8'h08 ##1
        data_address < 8'h40 |-> ram_select.bank == 2'h1) else $error("bank select");
    a_bank_two: assert property (@(posedge clock) disable iff (rst)
        data_write && data_address == 8'hcb && write_data == 8'h10 ##1
        data_address < 8'h40 |-> ram_select.bank == 2'h2) else $error("bank two");
    a_bank_enable: assert property (@(posedge clock) disable iff (rst)
        data_read && data_address < 8'h40 |-> ram_enable && region == mem_map_pkg::region_bank)
        else $error("bank enable");

    // Fixed slots of the data space.
    a_core_regs: assert property (@(posedge clock) disable iff (rst)
        data_address == 8'h82 |-> region == mem_map_pkg::region_core) else $error("core");
    a_ram_base: assert property (@(posedge clock) disable iff (rst)
        data_read && data_address >= 8'h84 && data_address <= 8'hbf
        |-> ram_enable && ram_select.bank == 2'h3) else $error("base ram");
    a_port_data: assert property (@(posedge clock) disable iff (rst)
        data_address[7:2] == 6'h30 |-> region == mem_map_pkg::region_port_data) else $error("pd");
    a_port_dir: assert property (@(posedge clock) disable iff (rst)
        data_address[7:2] == 6'h31 |-> region == mem_map_pkg::region_port_dir) else $error("pr");
    a_port_opt: assert property (@(posedge clock) disable iff (rst)
        data_address[7:2] == 6'h33 |-> region == mem_map_pkg::region_port_opt) else $error("po");
    a_accum_decode: assert property (@(posedge clock) disable iff (rst)
        data_address == 8'hff |-> region == mem_map_pkg::region_accumulator) else $error("acc");

    // Write-only locations flag a read, and nothing is flagged without a read.
    a_write_only: assert property (@(posedge clock) disable iff (rst)
        data_read && (data_address == 8'hc8 || data_address == 8'hdc) |-> write_only_read)
        else $error("write only");
    a_read_flags: assert property (@(posedge clock) disable iff (rst)
        !data_read |-> !write_only_read && !window_read)
        else $error("read flag without read");
    a_ram_idle: assert property (@(posedge clock) disable iff (rst)
        !data_read && !data_write |-> !ram_enable) else $error("ram enable idle");

    // Main scenarios worth seeing at least once.
    c_window: cover property (@(posedge clock) disable iff (rst) window_read);
    c_bank_two: cover property (@(posedge clock) disable iff (rst) ram_select.bank == 2'h2);
    c_dynamic: cover property (@(posedge clock) disable iff (rst)
        !program_counter[11] && fetch_address[12:11] == 2'h3);
endmodule // mem_page_decoder
`default_nettype wire

/* File: rtl/mem_map_cfg.svh */
// Address map, field positions and sizes of the memory paging and window decoder.
`ifndef MEM_MAP_CFG_SVH
`define MEM_MAP_CFG_SVH
`define ADDR_WINDOW_POSITION 8'hc9
`define ADDR_ROM_PAGE_SELECT 8'hca
`define ADDR_RAM_BANK_SELECT 8'hcb
`define ADDR_IRQ_OPTION 8'hc8
`define ADDR_SPI_IRQ_DISABLE 8'hdc
`define ADDR_CORE_X 8'h80
`define ADDR_CORE_Y 8'h81
`define ADDR_CORE_V 8'h82
`define ADDR_CORE_W 8'h83
`define ADDR_RAM_FIRST 8'h84
`define ADDR_RAM_LAST 8'hbf
`define ADDR_PORT_DATA 8'hc0
`define ADDR_PORT_DIR 8'hc4
`define ADDR_PORT_OPT 8'hcc
`define ADDR_ACCUMULATOR 8'hff
`define ADDR_WINDOW_FIRST 8'h40
`define ADDR_BANK_LAST 8'h3f
`define BANK_PAGE1_BIT 3
`define BANK_PAGE2_BIT 4
`define PC_STATIC_BIT 11
`define STATIC_PAGE 2'h1
`define STACK_DEPTH 6
`define STACK_WIDTH 12
`endif

/* File: rtl/mem_map_pkg.sv */
// Types shared by the memory paging and window decoder.
package mem_map_pkg;
    typedef enum logic [10:0] {
        region_bank = 11'h001,
        region_window = 11'h002,
        region_core = 11'h004,
        region_ram = 11'h008,
        region_port_data = 11'h010,
        region_port_dir = 11'h020,
        region_port_opt = 11'h040,
        region_write_only = 11'h080,
        region_accumulator = 11'h100,
        region_periph = 11'h200,
        region_unused = 11'h400
    } region_t;
    typedef struct packed {
        logic [1:0] bank;
        logic [5:0] offset;
    } ram_select_t;
    typedef struct packed {
        logic [11:0] address;
        logic push;
        logic pop;
    } stack_cmd_t;
endpackage

/* File: rtl/return_stack.sv */
// Six entry return address stack for calls and interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_cfg.svh"
module return_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int WIDTH = `STACK_WIDTH
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Push and pop requests with the address to save.
    input wire mem_map_pkg::stack_cmd_t cmd,
    // Entry on top of the stack.
    output logic [WIDTH-1:0] top
);
    logic [WIDTH-1:0] entry [DEPTH];
    logic [WIDTH-1:0] next_entry [DEPTH];

    // A push shifts every entry down one place; a pop shifts them up and keeps the bottom.
    for (genvar g = 0; g < DEPTH; g++) begin : gen_entry
        if (g == 0) begin : gen_first
            always_comb begin
                next_entry[g] = entry[g];
                if (cmd.push) begin
                    next_entry[g] = cmd.address[WIDTH-1:0];
                end else if (cmd.pop) begin
                    next_entry[g] = entry[g+1];
                end
            end
        end else if (g == DEPTH - 1) begin : gen_last
            always_comb begin
                next_entry[g] = entry[g];
                if (cmd.push) begin
                    next_entry[g] = entry[g-1];
                end
            end
        end else begin : gen_middle
            always_comb begin
                next_entry[g] = entry[g];
                if (cmd.push) begin
                    next_entry[g] = entry[g-1];
                end else if (cmd.pop) begin
                    next_entry[g] = entry[g+1];
                end
            end
        end
    end

    // Entries are stored in flip-flops.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) entry[i] <= '0;
        end else begin
            entry <= next_entry;
        end
    end

    assign top = entry[0];

    a_push_saves: assert property (@(posedge clock) disable iff (rst)
        cmd.push |=> top == $past(cmd.address)) else $error("push not on top");
    c_push: cover property (@(posedge clock) disable iff (rst) cmd.push);
endmodule // return_stack
`default_nettype wire

/* File: tb/core_model.sv */
// Processor core model that issues data space reads and writes.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock.
    input wire logic clock,
    // Data space access towards the decoder.
    output logic [7:0] data_address,
    output logic data_write,
    output logic data_read,
    output logic [7:0] write_data
);
    // Bus lines start idle.
    initial begin
        data_address = 8'h00;
        data_write = 1'b0;
        data_read = 1'b0;
        write_data = 8'h00;
    end
    // Whole byte write held up to the taking edge; the read line is held low during the write.
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        data_address <= addr;
        write_data <= data;
        data_read <= 1'b0;
        data_write <= 1'b1;
        @(posedge clock);
        data_write <= 1'b0;
        write_data <= ~data;
    endtask
    // Whole byte write followed at once by a level read, back to back.
    task automatic write_read(input logic [7:0] addr, input logic [7:0] data,
            input logic [7:0] raddr);
        @(posedge clock);
        data_address <= addr;
        write_data <= data;
        data_read <= 1'b0;
        data_write <= 1'b1;
        @(posedge clock);
        data_write <= 1'b0;
        write_data <= ~data;
        data_address <= raddr;
        data_read <= 1'b1;
    endtask
    // Level read that stays up until the next access replaces it.
    task automatic read_at(input logic [7:0] addr);
        @(posedge clock);
        data_address <= addr;
        data_read <= 1'b1;
    endtask
endmodule // core_model
`default_nettype wire

/* File: tb/mem_page_decoder_tb_top.sv */
// Testbench for the memory paging and window decoder.
`timescale 1ns/1ps
`default_nettype none
module mem_page_decoder_tb_top;
    logic clock = 1'b0;
    logic rst;
    logic [11:0] program_counter;
    logic [12:0] fetch_address, window_address;
    logic [7:0] data_address, write_data;
    logic data_write, data_read, window_read, ram_enable, write_only_read;
    mem_map_pkg::region_t region;
    mem_map_pkg::ram_select_t ram_select;
    mem_map_pkg::stack_cmd_t stack_cmd;
    logic [11:0] stack_top;
    logic protect_option;
    logic external_read;
    logic external_read_allow;
    int bad_count = 0;
    int checked = 0;
    // The clock toggles every half period of 12.5 ns.
    always #12.5 clock = ~clock;
    core_model core (.clock, .data_address, .data_write, .data_read, .write_data);
    mem_page_decoder uut (.clock, .rst, .program_counter, .fetch_address, .data_address,
        .data_write, .data_read, .write_data, .window_address, .window_read, .region,
        .ram_select, .ram_enable, .write_only_read, .stack_cmd, .stack_top,
        .protect_option, .external_read, .external_read_allow);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic set_pc(input logic [11:0] pc);
        @(posedge clock);
        program_counter <= pc;
        #1;
    endtask
    task automatic test_pages();
        for (int p = 0; p < 4; p++) begin
            core.write_byte(8'hca, 8'hfc | 8'(p));
            set_pc(12'h123);
            check(16'(fetch_address), {3'h0, 2'(p), 11'h123});
            set_pc(12'h923);
            check(16'(fetch_address), 16'h0923);
        end
    endtask
    task automatic test_window();
        core.write_byte(8'hc9, 8'h85);
        core.read_at(8'h41);
        #1;
        check(16'(window_read), 16'h1);
        check(16'(window_address), 16'h0141);
        core.write_byte(8'hc9, 8'h7f);
        core.read_at(8'h7f);
        #1;
        check(16'(window_address), 16'h1fff);
        core.read_at(8'h80);
        #1;
        check(16'(window_read), 16'h0);
    endtask
    task automatic test_decode();
        logic [7:0] addr [6] = '{8'h83, 8'h84, 8'hc3, 8'hc4, 8'hcf, 8'hff};
        logic [10:0] exp [6] = '{11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h100};
        for (int i = 0; i < 6; i++) begin
            core.read_at(addr[i]);
            #1;
            check(16'(region), 16'(exp[i]));
        end
    endtask
    task automatic test_write_only();
        logic [7:0] addr [5] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hdc};
        for (int i = 0; i < 5; i++) begin
            core.read_at(addr[i]);
            #1;
            check(16'(write_only_read), 16'h1);
        end
        core.read_at(8'h7f);
        set_pc(12'h123);
        check(16'(window_address), 16'h1fff);
        check(16'(fetch_address), 16'h1923);
    endtask
    task automatic test_bank();
        core.write_read(8'hcb, 8'h08, 8'h05);
        #1;
        check(16'(ram_select), 16'h0045);
        check(16'(ram_enable), 16'h1);
        core.write_read(8'hcb, 8'h10, 8'h3f);
        #1;
        check(16'(ram_select), 16'h00bf);
        check(16'(region), 16'h0001);
    endtask
    task automatic test_stack();
        for (int i = 1; i < 7; i++) begin
            @(posedge clock);
            stack_cmd <= {12'(i * 12'h111), 2'b10};
        end
        @(posedge clock);
        stack_cmd <= '0;
        #1;
        check(16'(stack_top), 16'h0666);
        check(16'(fetch_address), 16'h1923);
        for (int i = 5; i > 0; i--) begin
            @(posedge clock);
            stack_cmd <= 14'h0001;
            @(posedge clock);
            stack_cmd <= '0;
            #1;
            check(16'(stack_top), 16'(i * 16'h111));
        end
    endtask
    task automatic test_protect();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {protect_option, external_read} <= 2'(i);
            #1;
            check(16'(external_read_allow), 16'(i == 1));
        end
    endtask
    task automatic test_reset_keep();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        core.read_at(8'h40);
        #1;
        check(16'(window_address), 16'h1fc0);
        check(16'(fetch_address), 16'h1923);
        check(16'(stack_top), 16'h0000);
    endtask
    // Main sequence after an eight cycle reset, in which the unreset registers get values.
    initial begin
        rst = 1'b1;
        program_counter = 12'h000;
        stack_cmd = '0;
        protect_option = 1'b0;
        external_read = 1'b0;
        core.write_byte(8'hca, 8'h00);
        core.write_byte(8'hc9, 8'h00);
        core.write_byte(8'hcb, 8'h00);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        test_pages();
        test_window();
        test_decode();
        test_write_only();
        test_bank();
        test_stack();
        test_protect();
        test_reset_keep();
        give_verdict();
    end
    // Cuts a hung run short and counts it as a mismatch.
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        give_verdict();
    end
endmodule // mem_page_decoder_tb_top
`default_nettype wire
